// *** sbcsp_device.sv ***
// Register port of the system basis chip behind the serial link
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module sbcsp_device
  import sbcsp_pkg::*;
(
  input  wire logic    ref_clk,
  input  wire logic    rst,
  sbcsp_link_if.device link,
  input  wire logic    resetMode,
  input  wire logic    extReset,
  input  wire logic    supplyOvervoltage,
  input  wire logic    supplyUndervoltage,
  input  wire logic    regulatorOvertempWarning,
  input  wire logic [3:0] wakeInputStatus,
  input  wire logic [3:0] linPhyStatus,
  input  wire logic [3:0] highSideStatus,
  input  wire logic [3:0] lowSideStatus,
  input  wire logic [3:0] watchdogStatus,
  input  wire logic [3:0] interruptSource,
  output var  logic [1:0] modeSelect,
  output var  logic       overvoltageShutdownEnable,
  output var  logic       watchdogClear,
  output var  logic       driverShutdown,
  output var  logic       batteryFailFlag,
  output var  logic [3:0] wakeInputControl,
  output var  logic [3:0] linPhyControl,
  output var  logic [3:0] highSideControl,
  output var  logic [3:0] lowSideControl,
  output var  logic [3:0] timingControl,
  output var  logic [3:0] analogMuxControl,
  output var  logic [3:0] deviceConfiguration,
  output var  logic [3:0] interruptMask
);
  import sbcsp_pkg::*;

  logic [2:0]       linkSync;
  logic             csS;
  logic             sclkS;
  logic             mosiS;
  logic             csPrev_reg;
  logic             sclkPrev_reg;
  logic             csFall;
  logic             csRise;
  logic             sclkRise;
  logic             sclkFall;
  sbcsp_dev_state_t state_reg;
  logic [3:0]       edgeCnt_reg;
  logic [7:0]       rx_reg;
  logic [3:0]       addr_reg;
  logic [3:0]       summary_reg;
  logic [3:0]       snap_reg [0:7];
  logic [7:0]       replyByte;
  logic             commitValid;
  logic [3:0]       commitAddr;
  logic [3:0]       commitData;
  logic [3:0]       voltageStatus;
  logic [3:0]       linStatusRead;

  // Select, clock and data come from another domain
  // Select rides inverted so a cleared synchroniser reads as deselected;
  // otherwise a false select fall would follow every reset
  sbcsp_sync #(.W(3)) linkSyncInst (
    .ref_clk (ref_clk),
    .rst     (rst),
    .async   ({~link.csN, link.sclk, link.mosi}),
    .synced  (linkSync)
  );
  assign csS   = ~linkSync[2];
  assign sclkS = linkSync[1];
  assign mosiS = linkSync[0];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      csPrev_reg   <= 1'b1;
      sclkPrev_reg <= 1'b0;
    end else begin
      csPrev_reg   <= csS;
      sclkPrev_reg <= sclkS;
    end
  end

  assign csFall   = csPrev_reg & ~csS;
  assign csRise   = ~csPrev_reg & csS;
  assign sclkRise = ~sclkPrev_reg & sclkS & ~csS;
  assign sclkFall = sclkPrev_reg & ~sclkS & ~csS;

  assign voltageStatus = {supplyOvervoltage, supplyUndervoltage,
                          regulatorOvertempWarning, batteryFailFlag};
  assign linStatusRead = {linPhyStatus[3:1], 1'b0};

  // Address pairs share one status register, so index by address / 2
  function automatic logic [3:0] statusOf(input logic [3:0] a,
                                          input logic [3:0] s [0:7]);
    statusOf = s[a[3:1]];
  endfunction

  function automatic logic writable(input logic [3:0] a);
    writable = !a[0] || (a == ADDR_CONFIG);
  endfunction

  assign replyByte   = {summary_reg, statusOf(addr_reg, snap_reg)};
  assign commitValid = csRise && (state_reg == SBCSP_SHIFT)
                       && (edgeCnt_reg == VALID_EDGES);
  assign commitAddr  = rx_reg[7:4];
  assign commitData  = rx_reg[3:0];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg   <= SBCSP_IDLE;
      edgeCnt_reg <= 4'h0;
      rx_reg      <= 8'h00;
      addr_reg    <= 4'h0;
    end else begin
      case (state_reg)
        SBCSP_IDLE: begin
          if (csFall) begin
            state_reg   <= SBCSP_SHIFT;
            edgeCnt_reg <= 4'h0;
          end
        end
        SBCSP_SHIFT: begin
          if (csRise) begin
            state_reg <= SBCSP_IDLE;
          end else if (sclkFall) begin
            rx_reg <= {rx_reg[6:0], mosiS};
            // Saturate above eight so long frames stay invalid
            if (edgeCnt_reg <= VALID_EDGES) begin
              edgeCnt_reg <= edgeCnt_reg + 4'h1;
            end
            if (edgeCnt_reg == 4'h3) begin
              addr_reg <= {rx_reg[2:0], mosiS};
            end
          end
        end
        default: state_reg <= SBCSP_IDLE;
      endcase
    end
  end

  // Status is frozen at frame start so the reply is self-consistent
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      summary_reg <= 4'h0;
      for (int i = 0; i < 8; i++) begin
        snap_reg[i] <= 4'h0;
      end
    end else if (csFall && state_reg == SBCSP_IDLE) begin
      summary_reg <= {|voltageStatus, |linStatusRead,
                      |highSideStatus, |lowSideStatus};
      snap_reg[0] <= voltageStatus;
      snap_reg[1] <= wakeInputStatus;
      snap_reg[2] <= linStatusRead;
      snap_reg[3] <= highSideStatus;
      snap_reg[4] <= lowSideStatus;
      snap_reg[5] <= watchdogStatus;
      snap_reg[6] <= 4'h0;
      snap_reg[7] <= interruptSource;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      link.misoOut <= 1'b0;
      link.misoOe  <= 1'b0;
    end else if (csRise || csS) begin
      link.misoOe <= 1'b0;
    end else if (csFall && state_reg == SBCSP_IDLE) begin
      link.misoOe  <= 1'b1;
      link.misoOut <= |voltageStatus;
    end else if (sclkRise && edgeCnt_reg != 4'h0
                 && edgeCnt_reg < VALID_EDGES) begin
      link.misoOut <= replyByte[3'(7 - edgeCnt_reg)];
    end
  end

  // Control registers; hardware reset conditions outrank a commit
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      modeSelect                <= 2'h0;
      overvoltageShutdownEnable <= RST_MODE[MODE_OVERVOLTAGE_SHUTDOWN_ENABLE_BIT];
      wakeInputControl          <= RST_WAKE;
      linPhyControl             <= RST_OTHER;
      highSideControl           <= RST_OTHER;
      lowSideControl            <= RST_OTHER;
      timingControl             <= RST_OTHER;
      analogMuxControl          <= RST_OTHER;
      deviceConfiguration       <= RST_OTHER;
      interruptMask             <= RST_OTHER;
    end else if (resetMode || extReset) begin
      wakeInputControl <= RST_WAKE;
      // Slew and J2602 bits survive; only power-on clears them
      linPhyControl[LIN_RXONLY_BIT] <= 1'b0;
      highSideControl  <= RST_OTHER;
      lowSideControl   <= RST_OTHER;
      timingControl    <= RST_OTHER;
      analogMuxControl <= RST_OTHER;
      interruptMask    <= RST_OTHER;
    end else if (commitValid && writable(commitAddr)) begin
      case (commitAddr)
        ADDR_MODE: begin
          overvoltageShutdownEnable <= commitData[MODE_OVERVOLTAGE_SHUTDOWN_ENABLE_BIT];
          modeSelect                <= commitData[1:0];
        end
        ADDR_WAKE:   wakeInputControl    <= commitData;
        ADDR_LIN:    linPhyControl       <= commitData;
        ADDR_HIGH:   highSideControl     <= commitData;
        ADDR_LOW:    lowSideControl      <= commitData;
        ADDR_TIMING: timingControl       <= commitData;
        ADDR_AMUX:   analogMuxControl    <= commitData;
        ADDR_CONFIG: deviceConfiguration <= commitData;
        ADDR_IMASK:  interruptMask       <= commitData;
        default:     modeSelect          <= modeSelect;
      endcase
    end else if (overvoltageShutdownEnable && supplyOvervoltage) begin
      highSideControl <= RST_OTHER;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      batteryFailFlag <= 1'b1;
      watchdogClear   <= 1'b0;
      driverShutdown  <= 1'b0;
    end else begin
      if (commitValid && (commitAddr == ADDR_MODE
                          || commitAddr == ADDR_VOLT_RD)) begin
        batteryFailFlag <= 1'b0;
      end
      watchdogClear  <= commitValid && commitAddr == ADDR_MODE
                        && commitData[1:0] == MODE_NORMAL_WDC;
      driverShutdown <= overvoltageShutdownEnable
                        && supplyOvervoltage;
    end
  end
endmodule
`default_nettype wire

// *** sbcsp_pkg.sv ***
// Shared constants and types of the SPI register port and its controller
package sbcsp_pkg;
  localparam int          BYTE_BITS        = 8;
  localparam int          NIBBLE           = 4;
  localparam logic [3:0]  ADDR_MODE        = 4'h0;
  localparam logic [3:0]  ADDR_VOLT_RD     = 4'h1;
  localparam logic [3:0]  ADDR_WAKE        = 4'h2;
  localparam logic [3:0]  ADDR_LIN         = 4'h4;
  localparam logic [3:0]  ADDR_HIGH        = 4'h6;
  localparam logic [3:0]  ADDR_LOW         = 4'h8;
  localparam logic [3:0]  ADDR_TIMING      = 4'hA;
  localparam logic [3:0]  ADDR_AMUX        = 4'hC;
  localparam logic [3:0]  ADDR_CONFIG      = 4'hD;
  localparam logic [3:0]  ADDR_IMASK       = 4'hE;
  localparam int          MODE_OVERVOLTAGE_SHUTDOWN_ENABLE_BIT    = 3;
  localparam int          MODE_ZERO_BIT    = 2;
  localparam int          LIN_RXONLY_BIT   = 2;
  localparam logic [3:0]  RST_MODE         = 4'h8;
  localparam logic [3:0]  RST_WAKE         = 4'hF;
  localparam logic [3:0]  RST_OTHER        = 4'h0;
  localparam logic [1:0]  MODE_NORMAL_WDC  = 2'h3;
  localparam logic [3:0]  VALID_EDGES      = 4'h8;
  localparam int          CLK_PERIOD_NS    = 4;
  localparam int          SCLK_HALF_NS     = 40;
  localparam int          SCLK_HALF_CYC    = SCLK_HALF_NS / CLK_PERIOD_NS;
  localparam logic [7:0]  WB_CMD           = 8'h00;
  localparam logic [7:0]  WB_STATUS        = 8'h04;
  localparam logic [7:0]  WB_IRQ_STAT      = 8'h08;
  localparam logic [7:0]  WB_IRQ_MASK      = 8'h0C;
  localparam int          STAT_BUSY_BIT    = 8;
  localparam int          IRQ_DONE_BIT     = 0;
  localparam int          IRQ_SUMMARY_BIT  = 1;
  typedef enum logic {SBCSP_IDLE, SBCSP_SHIFT} sbcsp_dev_state_t;
  typedef enum logic [2:0] {
    SBCSP_H_IDLE, SBCSP_H_LEAD, SBCSP_H_HIGH, SBCSP_H_LOW, SBCSP_H_TRAIL
  } sbcsp_host_state_t;
endpackage

// *** sbcsp_link_if.sv ***
// Four-wire serial link between controller and register port
`timescale 1ns/1ns
`default_nettype none
interface sbcsp_link_if;
  logic csN;
  logic sclk;
  logic mosi;
  logic misoOut;
  logic misoOe;
  modport device (input csN, input sclk, input mosi,
                  output misoOut, output misoOe);
  modport host   (output csN, output sclk, output mosi,
                  input misoOut, input misoOe);
endinterface
`default_nettype wire

// *** sbcsp_sync.sv ***
// Two-flop synchroniser for a bundle of independent levels
`timescale 1ns/1ns
`default_nettype none
module sbcsp_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async,
  output var  logic [W-1:0] synced
);
  logic [W-1:0] stage1_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stage1_reg <= '0;
      synced     <= '0;
    end else begin
      stage1_reg <= async;
      synced     <= stage1_reg;
    end
  end
endmodule
`default_nettype wire

// *** sbcsp_host.sv ***
// Serial link master with a Wishbone register front end
`timescale 1ns/1ns
`default_nettype none
module sbcsp_host
  import sbcsp_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  sbcsp_link_if.host       link,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  output var  logic [31:0] dat_o,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        stb_i,
  input  wire logic        cyc_i,
  output var  logic        ack_o,
  output var  logic        irq
);
  import sbcsp_pkg::*;

  sbcsp_host_state_t state_reg;
  logic [7:0]        tx_reg;
  logic [7:0]        rx_reg;
  logic [3:0]        bitCnt_reg;
  logic [7:0]        timer_reg;
  logic              timerDone;
  logic [1:0]        irqStat_reg;
  logic [1:0]        irqMask_reg;
  logic              misoS;
  logic              access;
  logic              startCmd;
  logic              frameDone;
  logic              readIrq;

  // Device output comes from another domain
  sbcsp_sync #(.W(1)) misoSyncInst (
    .ref_clk (ref_clk),
    .rst     (rst),
    .async   (link.misoOut),
    .synced  (misoS)
  );

  assign access    = cyc_i && stb_i && !ack_o;
  assign startCmd  = access && we_i && sel_i[0] && adr_i == WB_CMD
                     && state_reg == SBCSP_H_IDLE;
  assign readIrq   = access && !we_i && adr_i == WB_IRQ_STAT;
  assign timerDone = timer_reg == 8'h00;
  assign frameDone = state_reg == SBCSP_H_TRAIL && timerDone;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg  <= SBCSP_H_IDLE;
      link.csN   <= 1'b1;
      link.sclk  <= 1'b0;
      link.mosi  <= 1'b0;
      tx_reg     <= 8'h00;
      rx_reg     <= 8'h00;
      bitCnt_reg <= 4'h0;
      timer_reg  <= 8'h00;
    end else begin
      if (!timerDone) begin
        timer_reg <= timer_reg - 8'h01;
      end
      case (state_reg)
        SBCSP_H_IDLE: begin
          if (startCmd) begin
            tx_reg     <= dat_i[7:0];
            link.csN   <= 1'b0;
            bitCnt_reg <= 4'h0;
            timer_reg  <= 8'(SCLK_HALF_CYC - 1);
            state_reg  <= SBCSP_H_LEAD;
          end
        end
        SBCSP_H_LEAD, SBCSP_H_LOW: begin
          if (timerDone) begin
            if (bitCnt_reg == VALID_EDGES) begin
              link.csN  <= 1'b1;
              timer_reg <= 8'(SCLK_HALF_CYC - 1);
              state_reg <= SBCSP_H_TRAIL;
            end else begin
              link.sclk <= 1'b1;
              link.mosi <= tx_reg[7];
              tx_reg    <= {tx_reg[6:0], 1'b0};
              timer_reg <= 8'(SCLK_HALF_CYC - 1);
              state_reg <= SBCSP_H_HIGH;
            end
          end
        end
        SBCSP_H_HIGH: begin
          if (timerDone) begin
            link.sclk  <= 1'b0;
            rx_reg     <= {rx_reg[6:0], misoS};
            bitCnt_reg <= bitCnt_reg + 4'h1;
            timer_reg  <= 8'(SCLK_HALF_CYC - 1);
            state_reg  <= SBCSP_H_LOW;
          end
        end
        SBCSP_H_TRAIL: begin
          // Select stays high a half period before the next frame
          if (timerDone) begin
            state_reg <= SBCSP_H_IDLE;
          end
        end
        default: state_reg <= SBCSP_H_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= access;
      dat_o <= 32'h0000_0000;
      if (access && !we_i) begin
        case (adr_i)
          WB_STATUS: begin
            dat_o[7:0]           <= rx_reg;
            dat_o[STAT_BUSY_BIT] <= state_reg != SBCSP_H_IDLE;
          end
          WB_IRQ_STAT: dat_o[1:0] <= irqStat_reg;
          WB_IRQ_MASK: dat_o[1:0] <= irqMask_reg;
          default:     dat_o      <= 32'h0000_0000;
        endcase
      end
    end
  end

  // A new event in the clearing read's cycle survives the clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irqStat_reg <= 2'h0;
      irqMask_reg <= 2'h0;
      irq         <= 1'b0;
    end else begin
      irqStat_reg[IRQ_DONE_BIT] <= frameDone
        || (irqStat_reg[IRQ_DONE_BIT] && !readIrq);
      irqStat_reg[IRQ_SUMMARY_BIT] <= (frameDone && |rx_reg[7:4])
        || (irqStat_reg[IRQ_SUMMARY_BIT] && !readIrq);
      if (access && we_i && sel_i[0] && adr_i == WB_IRQ_MASK) begin
        irqMask_reg <= dat_i[1:0];
      end
      irq <= |(irqStat_reg & irqMask_reg);
    end
  end
endmodule
`default_nettype wire

// *** sbcsp_link_sva.sv ***
// Link protocol assertions between controller and register port
`timescale 1ns/1ns
`default_nettype none
module sbcsp_link_sva (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic csN,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic misoOut,
  input wire logic misoOe
);
  logic [4:0] edgeCnt_reg;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Cleared only at select fall, so a fall on the select rise edge counts
  always_ff @(posedge ref_clk) begin
    if (rst || $fell(csN))
      edgeCnt_reg <= 5'h00;
    else if ($fell(sclk))
      edgeCnt_reg <= edgeCnt_reg + 5'h01;
  end
  property p_frame_edges; $rose(csN) |=> (edgeCnt_reg == 5'h08); endproperty
  a_frame_edges: assert property (p_frame_edges)
    else $error("frame without eight sampling edges");
  property p_select_drive; $fell(csN) |-> ##[1:6] misoOe; endproperty
  a_select_drive: assert property (p_select_drive)
    else $error("output not driven after select fall");
  property p_drive_hold; !csN [*6] |-> misoOe; endproperty
  a_drive_hold: assert property (p_drive_hold)
    else $error("output released inside frame");
  property p_release; csN [*6] |-> !misoOe; endproperty
  a_release: assert property (p_release)
    else $error("output driven while deselected");
  // Synchroniser delay puts each data change 3 or more cycles after the rise
  property p_miso_edge;
    (misoOe && $past(misoOe) && !csN && misoOut != $past(misoOut))
      |-> $past(sclk, 3);
  endproperty
  a_miso_edge: assert property (p_miso_edge)
    else $error("reply bit changed away from clock rise");
  property p_mosi_edge;
    (!csN && $past(!csN) && mosi != $past(mosi)) |-> $rose(sclk);
  endproperty
  a_mosi_edge: assert property (p_mosi_edge)
    else $error("command bit changed away from clock rise");
  property p_clk_idle; csN |-> !sclk; endproperty
  a_clk_idle: assert property (p_clk_idle)
    else $error("serial clock high while deselected");
  property p_half_period; $rose(sclk) |=> sclk [*8]; endproperty
  a_half_period: assert property (p_half_period)
    else $error("serial clock high phase too short");
  property p_gap; $rose(csN) |=> csN [*8]; endproperty
  a_gap: assert property (p_gap)
    else $error("select idle gap too short");
  c_frame: cover property ($rose(csN));
  c_drive: cover property ($rose(misoOe));
  c_data: cover property ($fell(sclk) && misoOut);
endmodule
`default_nettype wire

// *** sbc_spi_register_port_tb_top.sv ***
// Self-checking bench for the serial register port and its controller
`timescale 1ns/1ns
`default_nettype none
module sbc_spi_register_port_tb_top;
  import sbcsp_pkg::*;
  typedef struct packed {
    logic [3:0] adr;
    logic [3:0] ctl;
    logic [7:0] rep;
    logic [3:0] oadr;
    logic [3:0] octl;
  } sbcsp_row_t;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  wbAdr = 8'h00;
  logic [31:0] wbDatW = 32'h0;
  logic [31:0] wbDatR;
  logic        wbWe = 1'b0;
  logic        wbCyc = 1'b0;
  logic        wbStb = 1'b0;
  logic        wbAck, irq;
  logic        resetMode = 1'b0;
  logic        extReset = 1'b0;
  logic        supplyOvervoltage = 1'b0;
  logic        supplyUndervoltage = 1'b1;
  logic        regulatorOvertempWarning = 1'b0;
  logic [3:0]  wakeInputStatus = 4'h5;
  logic [3:0]  linPhyStatus = 4'h7;
  logic [3:0]  highSideStatus = 4'h0;
  logic [3:0]  lowSideStatus = 4'h9;
  logic [3:0]  watchdogStatus = 4'hA;
  logic [3:0]  interruptSource = 4'h3;
  logic [1:0]  modeSelect, modeSel2;
  logic        overvoltageShutdownEnable, watchdogClear, driverShutdown;
  logic        batteryFailFlag, batFlag2;
  logic [3:0]  wakeInputControl, linPhyControl, highSideControl;
  logic [3:0]  lowSideControl, timingControl, analogMuxControl;
  logic [3:0]  deviceConfiguration, interruptMask, wakeCtl2;
  logic [7:0]  rep;
  logic [31:0] q;
  int          miscompares = 0;
  int          nChecks = 0;
  int          cycles = 0;
  int          wdCnt = 0;
  sbcsp_row_t  rows [13] = '{
    '{4'h1, 4'h0, 8'hD5, 4'h0, 4'h8}, '{4'h0, 4'hB, 8'hD4, 4'h0, 4'hB},
    '{4'h2, 4'h3, 8'hD5, 4'h2, 4'h3}, '{4'h3, 4'hC, 8'hD5, 4'h2, 4'h3},
    '{4'h4, 4'hD, 8'hD6, 4'h4, 4'hD}, '{4'h6, 4'h6, 8'hD0, 4'h6, 4'h6},
    '{4'h8, 4'hA, 8'hD9, 4'h8, 4'hA}, '{4'hA, 4'h5, 8'hDA, 4'hA, 4'h5},
    '{4'hC, 4'h2, 8'hD0, 4'hC, 4'h2}, '{4'hD, 4'h7, 8'hD0, 4'hD, 4'h7},
    '{4'hE, 4'hF, 8'hD3, 4'hE, 4'hF}, '{4'h0, 4'h1, 8'hD4, 4'h0, 4'h1},
    '{4'hF, 4'h1, 8'hD3, 4'hE, 4'hF}};
  sbcsp_link_if link();
  sbcsp_link_if link2();
  sbcsp_host sbcsp_host_i (.ref_clk, .rst, .link(link), .adr_i(wbAdr),
    .dat_i(wbDatW), .dat_o(wbDatR), .we_i(wbWe), .sel_i(4'hF),
    .stb_i(wbStb), .cyc_i(wbCyc), .ack_o(wbAck), .irq);
  sbcsp_device sbcsp_device_i (.ref_clk, .rst, .link(link), .resetMode,
    .extReset, .supplyOvervoltage, .supplyUndervoltage,
    .regulatorOvertempWarning, .wakeInputStatus, .linPhyStatus,
    .highSideStatus, .lowSideStatus, .watchdogStatus, .interruptSource,
    .modeSelect, .overvoltageShutdownEnable, .watchdogClear,
    .driverShutdown, .batteryFailFlag, .wakeInputControl, .linPhyControl,
    .highSideControl, .lowSideControl, .timingControl, .analogMuxControl,
    .deviceConfiguration, .interruptMask);
  // Second port faces the bench directly so frames can be malformed
  sbcsp_device sbcsp_device_i2 (.ref_clk, .rst, .link(link2), .resetMode,
    .extReset, .supplyOvervoltage, .supplyUndervoltage,
    .regulatorOvertempWarning, .wakeInputStatus, .linPhyStatus,
    .highSideStatus, .lowSideStatus, .watchdogStatus, .interruptSource,
    .modeSelect(modeSel2), .overvoltageShutdownEnable(), .watchdogClear(),
    .driverShutdown(), .batteryFailFlag(batFlag2),
    .wakeInputControl(wakeCtl2), .linPhyControl(), .highSideControl(),
    .lowSideControl(), .timingControl(), .analogMuxControl(),
    .deviceConfiguration(), .interruptMask());
  sbcsp_link_sva sbcsp_link_sva_i (.ref_clk, .rst, .csN(link.csN),
    .sclk(link.sclk), .mosi(link.mosi), .misoOut(link.misoOut),
    .misoOe(link.misoOe));
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (watchdogClear === 1'b1)
      wdCnt <= wdCnt + 1;
    if (cycles == 20000) begin
      miscompares++;
      $display("[FAIL] %0t run too long", $time);
      closeOut();
    end
  end
  task automatic closeOut();
    if (miscompares == 0 && nChecks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic [7:0] a, input logic w,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge ref_clk);
    wbAdr <= a;
    wbWe <= w;
    wbDatW <= d;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    r = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    if (n == 20) begin
      miscompares++;
      $display("[FAIL] %0t no bus answer", $time);
    end
  endtask
  task automatic xfer(input logic [3:0] a, input logic [3:0] c,
                      output logic [7:0] r);
    logic [31:0] s;
    int n;
    n = 0;
    wb(WB_CMD, 1'b1, {24'h0, a, c}, s);
    do begin
      wb(WB_STATUS, 1'b0, 32'h0, s);
      n++;
    end while (s[STAT_BUSY_BIT] !== 1'b0 && n < 200);
    r = s[7:0];
  endtask
  task automatic bang(input logic [7:0] b, input int n, output logic [7:0] r);
    link2.csN <= 1'b0;
    repeat (10) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      link2.sclk <= 1'b1;
      link2.mosi <= b[7 - (i % 8)];
      repeat (10) @(posedge ref_clk);
      link2.sclk <= 1'b0;
      r = {r[6:0], link2.misoOut};
      chk(link2.misoOe, 1'b1);
      repeat (10) @(posedge ref_clk);
    end
    link2.csN <= 1'b1;
    link2.mosi <= ~link2.mosi;
    repeat (12) @(posedge ref_clk);
    chk(link2.misoOe, 1'b0);
  endtask
  function automatic logic [3:0] ctlOf(input logic [3:0] a);
    case (a)
      ADDR_MODE: ctlOf = {overvoltageShutdownEnable, 1'b0, modeSelect};
      ADDR_WAKE: ctlOf = wakeInputControl;
      ADDR_LIN: ctlOf = linPhyControl;
      ADDR_HIGH: ctlOf = highSideControl;
      ADDR_LOW: ctlOf = lowSideControl;
      ADDR_TIMING: ctlOf = timingControl;
      ADDR_AMUX: ctlOf = analogMuxControl;
      ADDR_CONFIG: ctlOf = deviceConfiguration;
      ADDR_IMASK: ctlOf = interruptMask;
      default: ctlOf = 4'hX;
    endcase
  endfunction
  initial begin
    link2.csN = 1'b1;
    link2.sclk = 1'b0;
    link2.mosi = 1'b0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk({batteryFailFlag, overvoltageShutdownEnable, modeSelect,
         wakeInputControl, linPhyControl, highSideControl, lowSideControl},
        {4'hC, 4'hF, 12'h0});
    chk({timingControl, analogMuxControl, deviceConfiguration,
         interruptMask, link.csN, link.misoOe}, 18'h2);
    foreach (rows[i]) begin
      xfer(rows[i].adr, rows[i].ctl, rep);
      chk(rep, rows[i].rep);
      chk(ctlOf(rows[i].oadr), rows[i].octl);
    end
    chk(wdCnt, 1);
    supplyOvervoltage <= 1'b1;
    regulatorOvertempWarning <= 1'b1;
    highSideStatus <= 4'h4;
    repeat (4) @(posedge ref_clk);
    chk(driverShutdown, 1'b0);
    xfer(ADDR_MODE, 4'h8, rep);
    chk(rep, 8'hFE);
    chk({driverShutdown, highSideControl}, 5'h10);
    supplyOvervoltage <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk(driverShutdown, 1'b0);
    wb(WB_IRQ_STAT, 1'b0, 32'h0, q);
    wb(WB_IRQ_MASK, 1'b1, 32'h1, q);
    interruptSource <= 4'hC;
    xfer(4'hF, 4'h0, rep);
    chk(rep, 8'hFC);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b1);
    wb(WB_IRQ_STAT, 1'b0, 32'h0, q);
    chk(q, 32'h3);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b0);
    wb(WB_IRQ_MASK, 1'b1, 32'h0, q);
    xfer(4'hF, 4'h0, rep);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b0);
    wb(WB_IRQ_STAT, 1'b0, 32'h0, q);
    chk(q, 32'h3);
    wb(8'h10, 1'b0, 32'h0, q);
    chk(q, 32'h0);
    resetMode <= 1'b1;
    @(posedge ref_clk);
    resetMode <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk({wakeInputControl, linPhyControl, lowSideControl, interruptMask,
         overvoltageShutdownEnable, modeSelect}, 19'h7C804);
    xfer(ADDR_WAKE, 4'h1, rep);
    extReset <= 1'b1;
    @(posedge ref_clk);
    extReset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(wakeInputControl, 4'hF);
    bang({ADDR_MODE, 4'h3}, 7, rep);
    chk({modeSel2, batFlag2}, 3'h1);
    bang({ADDR_WAKE, 4'h6}, 8, rep);
    chk(rep, 8'hF5);
    chk(wakeCtl2, 4'h6);
    bang({ADDR_WAKE, 4'h1}, 9, rep);
    chk({wakeCtl2, batFlag2}, 5'hD);
    rst <= 1'b1;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk({batteryFailFlag, wakeInputControl, modeSelect}, 7'h7C);
    repeat (2) @(posedge ref_clk);
    chk({link.misoOe, link2.misoOe}, 2'h0);
    closeOut();
  end
endmodule
`default_nettype wire
